/* rtl/voice_trigger_mode_control.v */
`timescale 1ns/1ns
`include "voice_trigger_regs.vh"

// Function
// - main control, frame gathering unit and analysis port run at the same time
// - recognition listens at low power, extracts on speech, wakes on a match
// - after extraction and comparison the block returns to low-power listening
// - training captures three utterances of up to 1.5 s into templates
// - mode select command over the control port enters training mode
// - templates can be read out and written back, then recognise directly
// - one phrase active; loading another template set replaces it
// - after power-up a short init, then idle waiting for the host
// - power loss clears memory; host reloads image and templates
// - wake output polarity and duration set over the control port
// - control port is a slave only, address 0x62, up to 100 kbit/s
// - analog input by default; digital mode drives mic clock, takes PDM data
module voice_trigger_mode_control #(
	parameter UTTER_CYCLES = `UTTER_CYCLES,
	parameter MS_CYCLES = `MS_CYCLES
) (
	// clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// control port pins
	input wire i_scl,
	input wire i_sda,
	output reg o_sda_out,
	output reg o_sda_oe,
	// wake pin
	output reg o_wake,
	// microphones
	input wire i_pdm_mic_data_in,
	output reg o_pdm_mic_clock_out,
	input wire [7:0] i_adc_data,
	input wire i_adc_valid,
	output reg o_adc_ready,
	// frames toward the analysis coprocessor
	output reg [7:0] o_frame_data,
	output reg o_frame_valid,
	input wire i_frame_ready,
	// algorithm core handshake
	input wire i_speech_detect,
	input wire i_compare_done,
	input wire i_match,
	input wire [7:0] i_feat_data,
	input wire i_feat_valid,
	// status
	output reg o_extract,
	output reg o_low_power,
	output reg o_template_valid,
	output reg o_digital_mic
);
	localparam I_IDLE = 3'd0, I_ADDR = 3'd1, I_ACK_A = 3'd2, I_WR = 3'd3;
	localparam I_ACK_W = 3'd4, I_RD = 3'd5, I_ACK_R = 3'd6;
	localparam M_INIT = 3'd0, M_IDLE = 3'd1, M_LISTEN = 3'd2, M_EXTRACT = 3'd3;
	localparam M_WAKE = 3'd4, M_TRAIN_WAIT = 3'd5, M_TRAIN_CAP = 3'd6;

	reg [7:0] tmpl_mem [0:`TMPL_DEPTH-1];
	reg scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, pdm_m, pdm_s;
	reg [2:0] i2c_state;
	reg [3:0] bitc;
	reg [7:0] rx_sh, tx_sh, cmd;
	reg rw, nack;
	reg [1:0] widx;
	reg [5:0] ptr;
	reg image_loaded, wake_pol;
	reg [7:0] wake_dur;
	reg mode_req;
	reg [7:0] mode_req_val;
	reg [2:0] state;
	reg [5:0] init_cnt;
	reg [31:0] tmr;
	reg [7:0] ms_left;
	reg [1:0] utter_cnt;
	reg [5:0] feat_ptr;
	reg [3:0] pdm_div;
	reg [7:0] pdm_sh;
	reg [2:0] pdm_bits;
	reg pdm_rdy;
	reg [7:0] fifo1;
	reg [1:0] fcnt;

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire i2c_start = scl_s & scl_d & sda_d & ~sda_s;
	wire i2c_stop = scl_s & scl_d & ~sda_d & sda_s;
	wire [7:0] status_byte = {image_loaded, o_template_valid, utter_cnt, o_digital_mic, state};
	wire [7:0] rd_byte = (cmd == `CMD_TMPL_RD) ? tmpl_mem[ptr] : status_byte;
	wire gathering = (state != M_INIT) && (state != M_IDLE);
	wire push_in = gathering && ~o_adc_ready ? 1'b0 :
		gathering && (o_digital_mic ? pdm_rdy : i_adc_valid);
	wire [7:0] in_word = o_digital_mic ? pdm_sh : i_adc_data;
	wire pop = o_frame_valid & i_frame_ready;
	wire [1:0] next_fcnt = fcnt + {1'b0, push_in} - {1'b0, pop};

	// pins from outside pass two flops; only the second is read
	always @(posedge i_clk) begin
		scl_m <= i_scl;
		scl_s <= scl_m;
		sda_m <= i_sda;
		sda_s <= sda_m;
		pdm_m <= i_pdm_mic_data_in;
		pdm_s <= pdm_m;
		if (i_sys_rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// control port slave: never drives clock, only pulls data low
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			i2c_state <= I_IDLE;
			bitc <= 4'h0;
			rx_sh <= 8'h00;
			tx_sh <= 8'h00;
			cmd <= 8'h00;
			rw <= 1'b0;
			nack <= 1'b0;
			widx <= 2'h0;
			ptr <= 6'h00;
			o_sda_out <= 1'b0;
			o_sda_oe <= 1'b0;
			image_loaded <= 1'b0;
			wake_pol <= `WAKE_POL_RST;
			wake_dur <= `WAKE_DUR_RST;
			o_digital_mic <= 1'b0;
			mode_req <= 1'b0;
			mode_req_val <= 8'h00;
		end else begin
			mode_req <= 1'b0;
			if (i2c_start) begin
				i2c_state <= I_ADDR;
				bitc <= 4'h0;
				o_sda_oe <= 1'b0;
			end else if (i2c_stop) begin
				i2c_state <= I_IDLE;
				o_sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (i2c_state == I_ADDR || i2c_state == I_WR || i2c_state == I_RD)
					bitc <= bitc + 4'h1;
				if (i2c_state == I_ADDR || i2c_state == I_WR)
					rx_sh <= {rx_sh[6:0], sda_s};
				if (i2c_state == I_ACK_R)
					nack <= sda_s;
			end else if (scl_fall) begin
				case (i2c_state)
				I_ADDR: if (bitc == 4'h8) begin
					if (rx_sh[7:1] == `I2C_DEV_ADDR) begin
						i2c_state <= I_ACK_A;
						o_sda_oe <= 1'b1;
						rw <= rx_sh[0];
						widx <= 2'h0;
					end else
						i2c_state <= I_IDLE;
				end
				I_ACK_A, I_ACK_R: begin
					if (i2c_state == I_ACK_R && nack) begin
						i2c_state <= I_IDLE;
						o_sda_oe <= 1'b0;
					end else if (rw) begin
						tx_sh <= rd_byte;
						o_sda_oe <= ~rd_byte[7];
						if (cmd == `CMD_TMPL_RD)
							ptr <= ptr + 6'h01;
						i2c_state <= I_RD;
						bitc <= 4'h0;
					end else begin
						o_sda_oe <= 1'b0;
						i2c_state <= I_WR;
						bitc <= 4'h0;
					end
				end
				I_WR: if (bitc == 4'h8) begin
					o_sda_oe <= 1'b1;
					i2c_state <= I_ACK_W;
					if (widx != 2'h3)
						widx <= widx + 2'h1;
					if (widx == 2'h0) begin
						cmd <= rx_sh;
						ptr <= 6'h00;
					end else case (cmd)
					`CMD_MODE: begin
						mode_req <= 1'b1;
						mode_req_val <= rx_sh;
					end
					`CMD_WAKE_CFG: if (widx == 2'h1)
						wake_pol <= rx_sh[0];
					else
						wake_dur <= rx_sh;
					`CMD_MIC_SEL: o_digital_mic <= rx_sh[0];
					`CMD_IMAGE_LOAD: image_loaded <= 1'b1;
					default: ;
					endcase
				end
				I_ACK_W: begin
					o_sda_oe <= 1'b0;
					i2c_state <= I_WR;
					bitc <= 4'h0;
				end
				I_RD: if (bitc == 4'h8) begin
					o_sda_oe <= 1'b0;
					nack <= 1'b0;
					i2c_state <= I_ACK_R;
				end else begin
					o_sda_oe <= ~tx_sh[6];
					tx_sh <= {tx_sh[6:0], 1'b0};
				end
				default: i2c_state <= I_IDLE;
				endcase
			end
			// host write pointer steps after each template byte; training capture uses its own feat_ptr
			if (scl_fall && i2c_state == I_WR && bitc == 4'h8 && widx != 2'h0 &&
				cmd == `CMD_TMPL_WR)
				ptr <= ptr + 6'h01;
		end
	end

	// template memory: host writes win over capture of features
	wire host_tmpl_wr = scl_fall && i2c_state == I_WR && bitc == 4'h8 && widx != 2'h0 &&
		cmd == `CMD_TMPL_WR && ~i2c_start && ~i2c_stop;
	always @(posedge i_clk) begin
		if (host_tmpl_wr)
			tmpl_mem[ptr] <= rx_sh;
		else if (state == M_TRAIN_CAP && i_feat_valid)
			tmpl_mem[feat_ptr] <= i_feat_data;
	end

	// main core sequencing
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= M_INIT;
			init_cnt <= 6'h00;
			tmr <= 32'h0;
			ms_left <= 8'h00;
			utter_cnt <= 2'h0;
			feat_ptr <= 6'h00;
			o_template_valid <= 1'b0;
			o_wake <= ~`WAKE_POL_RST;
			o_extract <= 1'b0;
			o_low_power <= 1'b0;
		end else begin
			o_wake <= (state == M_WAKE) ? wake_pol : ~wake_pol;
			o_extract <= (state == M_EXTRACT) || (state == M_TRAIN_CAP);
			o_low_power <= (state == M_LISTEN) || (state == M_TRAIN_WAIT);
			// a new set replaces the active phrase once fully written
			if (host_tmpl_wr) begin
				o_template_valid <= (ptr == 6'h3F);
				utter_cnt <= 2'h0;
			end
			if (state == M_TRAIN_CAP && i_feat_valid)
				feat_ptr <= feat_ptr + 6'h01;
			if (mode_req && state != M_INIT) begin
				if (mode_req_val == `MODE_TRAIN) begin
					state <= M_TRAIN_WAIT;
					utter_cnt <= 2'h0;
					feat_ptr <= 6'h00;
					o_template_valid <= 1'b0;
				end else if (mode_req_val == `MODE_RECOG) begin
					// refused without templates and image
					if (o_template_valid && image_loaded)
						state <= M_LISTEN;
				end else
					state <= M_IDLE;
			end else case (state)
			M_INIT: if (init_cnt == `INIT_CYCLES)
				state <= M_IDLE;
			else
				init_cnt <= init_cnt + 6'h01;
			M_IDLE: ;
			M_LISTEN: if (i_speech_detect)
				state <= M_EXTRACT;
			M_EXTRACT: if (i_compare_done) begin
				if (i_match) begin
					state <= M_WAKE;
					ms_left <= (wake_dur == 8'h00) ? 8'h01 : wake_dur;
					tmr <= 32'h0;
				end else
					state <= M_LISTEN;
			end
			M_WAKE: if (tmr == MS_CYCLES - 1) begin
				tmr <= 32'h0;
				ms_left <= ms_left - 8'h01;
				if (ms_left == 8'h01)
					state <= M_LISTEN;
			end else
				tmr <= tmr + 32'h1;
			M_TRAIN_WAIT: if (i_speech_detect) begin
				state <= M_TRAIN_CAP;
				tmr <= 32'h0;
			end
			M_TRAIN_CAP: if (i_compare_done || tmr == UTTER_CYCLES - 1) begin
				utter_cnt <= utter_cnt + 2'h1;
				if (utter_cnt == `TRAIN_UTTERS - 2'h1) begin
					o_template_valid <= 1'b1;
					state <= M_IDLE;
				end else
					state <= M_TRAIN_WAIT;
			end else
				tmr <= tmr + 32'h1;
			default: state <= M_IDLE;
			endcase
		end
	end

	// frame gathering: pdm clock from divider, bits packed into bytes
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			pdm_div <= 4'h0;
			o_pdm_mic_clock_out <= 1'b0;
			pdm_sh <= 8'h00;
			pdm_bits <= 3'h0;
			pdm_rdy <= 1'b0;
		end else begin
			if (~o_digital_mic) begin
				pdm_div <= 4'h0;
				o_pdm_mic_clock_out <= 1'b0;
			end else if (pdm_div == `PDM_HALF) begin
				pdm_div <= 4'h0;
				o_pdm_mic_clock_out <= ~o_pdm_mic_clock_out;
			end else
				pdm_div <= pdm_div + 4'h1;
			if (push_in && o_digital_mic)
				pdm_rdy <= 1'b0;
			// a stalled byte holds; bits arriving meanwhile are dropped
			else if (o_digital_mic && ~pdm_rdy && pdm_div == `PDM_HALF &&
				~o_pdm_mic_clock_out) begin
				pdm_sh <= {pdm_sh[6:0], pdm_s};
				pdm_bits <= pdm_bits + 3'h1;
				if (pdm_bits == 3'h7)
					pdm_rdy <= 1'b1;
			end
		end
	end

	// two-entry buffer toward the coprocessor
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			fcnt <= 2'h0;
			fifo1 <= 8'h00;
			o_frame_data <= 8'h00;
			o_frame_valid <= 1'b0;
			o_adc_ready <= 1'b1;
		end else begin
			fcnt <= next_fcnt;
			o_frame_valid <= (next_fcnt != 2'h0);
			o_adc_ready <= (next_fcnt != 2'h2);
			if (pop) begin
				if (push_in && fcnt == 2'h1)
					o_frame_data <= in_word;
				else
					o_frame_data <= fifo1;
				if (push_in && fcnt == 2'h2)
					fifo1 <= in_word;
			end else if (push_in) begin
				if (fcnt == 2'h0)
					o_frame_data <= in_word;
				else
					fifo1 <= in_word;
			end
		end
	end
endmodule

/* rtl/voice_trigger_regs.vh */
`ifndef VOICE_TRIGGER_REGS_VH
`define VOICE_TRIGGER_REGS_VH
// control port address and command codes
`define I2C_DEV_ADDR 7'h62
`define CMD_MODE 8'h01
`define CMD_WAKE_CFG 8'h02
`define CMD_MIC_SEL 8'h03
`define CMD_IMAGE_LOAD 8'h04
`define CMD_TMPL_WR 8'h05
`define CMD_TMPL_RD 8'h06
// mode codes carried by the mode select command
`define MODE_IDLE 8'h00
`define MODE_TRAIN 8'h01
`define MODE_RECOG 8'h02
// reset values
`define WAKE_POL_RST 1'b1
`define WAKE_DUR_RST 8'h01
// timing
`define CLK_KHZ 50000
`define INIT_CYCLES 6'h20
`define UTTER_MS 1500
`define UTTER_CYCLES (`UTTER_MS * `CLK_KHZ)
`define MS_CYCLES `CLK_KHZ
`define PDM_HALF 4'hF
`define TRAIN_UTTERS 2'h3
`define TMPL_DEPTH 64
`endif

/* sim/voice_trigger_mode_control_assertions.sv */
`timescale 1ns/1ns
module voice_trigger_checker (
	// clock and reset
	input wire i_clk,
	input wire i_sys_rst,
	// watched ports
	input wire o_sda_out,
	input wire o_sda_oe,
	input wire o_wake,
	input wire o_pdm_mic_clock_out,
	input wire o_digital_mic,
	input wire o_adc_ready,
	input wire o_frame_valid,
	input wire [7:0] o_frame_data,
	input wire i_frame_ready,
	input wire i_speech_detect,
	input wire i_compare_done,
	input wire i_match,
	input wire o_extract,
	input wire o_low_power
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sda_low_a: assert property (o_sda_oe |-> !o_sda_out)
		else $error("data pin driven high");
	mic_off_a: assert property (!o_digital_mic |=> !o_pdm_mic_clock_out)
		else $error("mic clock runs in analog mode");
	mic_rate_a: assert property (o_digital_mic && $changed(o_pdm_mic_clock_out) |=>
		($stable(o_pdm_mic_clock_out) || !o_digital_mic)[*8]) else $error("mic clock too fast");
	listen_excl_a: assert property (o_extract |-> !o_low_power)
		else $error("extracting while listening");
	speech_start_a: assert property (o_low_power && i_speech_detect |-> ##[1:2] o_extract)
		else $error("speech did not start extraction");
	quiet_hold_a: assert property (o_low_power && !i_speech_detect &&
		!$past(i_speech_detect) |=> !o_extract)
		else $error("extraction without speech");
	full_valid_a: assert property (!o_adc_ready |-> o_frame_valid)
		else $error("full buffer shows no frame");
	frame_hold_a: assert property (o_frame_valid && !i_frame_ready |=>
		o_frame_valid && $stable(o_frame_data)) else $error("stalled frame lost");
	wake_fire_a: assert property (o_extract && i_compare_done && i_match |->
		##[1:2] $changed(o_wake)) else $error("match gave no wake");
endmodule

/* sim/i2c_host_model.sv */
`timescale 1ns/1ns
module i2c_host_model (
	input wire i_clk,
	input wire i_oe,
	output reg o_scl = 1'b1,
	output wire o_sda
);
	reg low = 1'b0;
	reg acked;
	reg [7:0] b [0:65];
	reg [7:0] q [0:63];
	// pull-up: a released line reads high
	assign o_sda = ~(low | i_oe);
	task wt(input integer n);
		repeat (n) @(posedge i_clk);
	endtask
	// data moves one clock after the fall so start/stop are never faked
	task bitx(input v, output r);
		begin
			o_scl <= 1'b0;
			wt(1);
			low <= ~v;
			wt(3);
			o_scl <= 1'b1;
			wt(2);
			@(negedge i_clk) r = o_sda;
			wt(2);
		end
	endtask
	task xfer(input integer n, input integer nr);
		integer i, j;
		reg r;
		begin
			acked = 1'b1;
			wt(1);
			low <= 1'b1;
			wt(4);
			for (i = 0; i < n; i++) begin
				for (j = 7; j >= 0; j--)
					bitx(b[i][j], r);
				bitx(1'b1, r);
				if (r) acked = 1'b0;
			end
			// read bytes: ack all but the last so the slave lets go of data
			for (i = 0; i < nr; i++) begin
				for (j = 7; j >= 0; j--) begin
					bitx(1'b1, r);
					q[i][j] = r;
				end
				bitx(i == nr - 1, r);
			end
			o_scl <= 1'b0;
			wt(1);
			low <= 1'b1;
			wt(3);
			o_scl <= 1'b1;
			wt(4);
			low <= 1'b0;
			wt(8);
		end
	endtask
endmodule

/* sim/voice_trigger_mode_control_tb.sv */
`timescale 1ns/1ns
`include "voice_trigger_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED %0t line %0d", $time, `__LINE__); end end
module voice_trigger_mode_control_tb;
	localparam MSC = 10;
	reg i_clk = 0;
	reg rst = 1;
	reg av = 0, fr = 0, sp = 0, cd = 0, mt = 0, fv = 0, pdm = 0, pv;
	reg [7:0] ad = 8'h00, fd = 8'h00;
	wire scl, sda, sda_out, sda_oe, wake, pclk, ardy, fvalid, ext, lp, tv, dm;
	wire [7:0] fdata;
	integer num_errors = 0, n_tests = 0, k, n;
	voice_trigger_mode_control #(.UTTER_CYCLES(200), .MS_CYCLES(MSC)) i_dut (
		.i_clk(i_clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .o_wake(wake), .i_pdm_mic_data_in(pdm), .o_pdm_mic_clock_out(pclk),
		.i_adc_data(ad), .i_adc_valid(av), .o_adc_ready(ardy), .o_frame_data(fdata),
		.o_frame_valid(fvalid), .i_frame_ready(fr), .i_speech_detect(sp), .i_compare_done(cd),
		.i_match(mt), .i_feat_data(fd), .i_feat_valid(fv), .o_extract(ext), .o_low_power(lp),
		.o_template_valid(tv), .o_digital_mic(dm));
	i2c_host_model i_host (.i_clk(i_clk), .i_oe(sda_oe), .o_scl(scl), .o_sda(sda));
	initial forever #10 i_clk = ~i_clk;
	always @(posedge i_clk) pdm <= ~pdm;
	task stop_test;
		begin
			if (num_errors == 0 && n_tests > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	task tick(input integer c);
		repeat (c) @(posedge i_clk);
	endtask
	task send(input [7:0] c, input [7:0] d0, input [7:0] d1, input integer nb);
		begin
			i_host.b[0] = {`I2C_DEV_ADDR, 1'b0};
			i_host.b[1] = c;
			i_host.b[2] = d0;
			i_host.b[3] = d1;
			i_host.xfer(nb, 0);
		end
	endtask
	task event_run(input d, input m);
		begin
			sp <= 1'b1;
			tick(1);
			sp <= 1'b0;
			for (k = 0; k < 8 && ext !== 1'b1; k++) @(negedge i_clk);
			`CHK(ext, 1'b1)
			tick(1);
			fd <= 8'h5A;
			fv <= 1'b1;
			tick(1);
			fv <= 1'b0;
			cd <= d;
			mt <= m;
			tick(1);
			cd <= 1'b0;
			mt <= 1'b0;
		end
	endtask
	task wake_len(input idle, output integer len);
		begin
			len = 0;
			for (k = 0; k < 8 && wake === idle; k++) @(negedge i_clk);
			for (k = 0; k < 300 && wake === !idle; k++) begin
				len++;
				@(negedge i_clk);
			end
		end
	endtask
	initial begin
		#1000000;
		num_errors++;
		stop_test;
	end
	initial begin
		tick(6);
		rst <= 1'b0;
		@(negedge i_clk);
		`CHK({wake, pclk, fvalid, ardy, tv, dm, sda_oe}, 7'b0001000)
		tick(40);
		i_host.b[0] = 8'hC6;
		i_host.b[1] = `CMD_MODE;
		i_host.b[2] = `MODE_TRAIN;
		i_host.xfer(3, 0);
		`CHK({i_host.acked, lp}, 2'b00)
		send(`CMD_MODE, `MODE_RECOG, 8'h00, 3);
		`CHK({i_host.acked, lp}, 2'b10)
		for (n = 0; n < 64; n++) i_host.b[n + 2] = n[7:0];
		send(`CMD_TMPL_WR, 8'h00, 8'h01, 66);
		`CHK(tv, 1'b1)
		send(`CMD_TMPL_RD, 8'h00, 8'h00, 2);
		i_host.b[0] = {`I2C_DEV_ADDR, 1'b1};
		i_host.xfer(1, 64);
		for (n = 0; n < 64; n++)
			`CHK(i_host.q[n], n[7:0])
		send(`CMD_IMAGE_LOAD, 8'h00, 8'h00, 3);
		send(`CMD_MODE, `MODE_RECOG, 8'h00, 3);
		`CHK(lp, 1'b1)
		send(`CMD_WAKE_CFG, 8'h01, 8'h03, 4);
		event_run(1'b1, 1'b1);
		wake_len(1'b0, n);
		`CHK(n, 3 * MSC)
		@(negedge i_clk);
		`CHK(lp, 1'b1)
		tick(1);
		event_run(1'b1, 1'b0);
		wake_len(1'b0, n);
		`CHK({n[7:0], lp}, 9'h001)
		tick(1);
		send(`CMD_WAKE_CFG, 8'h00, 8'h02, 4);
		`CHK(wake, 1'b1)
		event_run(1'b1, 1'b1);
		wake_len(1'b1, n);
		`CHK(n, 2 * MSC)
		tick(1);
		send(`CMD_MODE, `MODE_TRAIN, 8'h00, 3);
		`CHK({lp, tv}, 2'b10)
		event_run(1'b1, 1'b0);
		tick(2);
		event_run(1'b1, 1'b0);
		tick(2);
		`CHK(tv, 1'b0)
		event_run(1'b0, 1'b0);
		for (k = 0; k < 300 && tv !== 1'b1; k++) @(negedge i_clk);
		`CHK({tv, lp}, 2'b10)
		tick(1);
		send(`CMD_MIC_SEL, 8'h01, 8'h00, 3);
		send(`CMD_IMAGE_LOAD, 8'h00, 8'h00, 3);
		n = 0;
		pv = pclk;
		for (k = 0; k < 64; k++) begin
			@(negedge i_clk);
			if (pclk !== pv) n++;
			pv = pclk;
		end
		`CHK({dm, n[7:0]}, 9'h104)
		tick(1);
		send(`CMD_MIC_SEL, 8'h00, 8'h00, 3);
		`CHK({dm, pclk}, 2'b00)
		send(`CMD_MODE, `MODE_RECOG, 8'h00, 3);
		`CHK(lp, 1'b1)
		av <= 1'b1;
		ad <= 8'hA0;
		n = 0;
		for (k = 0; k < 6; k++) begin
			@(negedge i_clk);
			if (ardy === 1'b1) begin
				n++;
				tick(1);
				ad <= ad + 8'h01;
			end
		end
		`CHK(n, 2)
		tick(1);
		av <= 1'b0;
		fr <= 1'b1;
		for (n = 0; n < 2; n++) begin
			@(negedge i_clk);
			`CHK({fvalid, fdata}, {1'b1, 8'hA0 + n[7:0]})
		end
		@(negedge i_clk);
		`CHK(fvalid, 1'b0)
		send(`CMD_MODE, `MODE_IDLE, 8'h00, 3);
		`CHK({lp, ext}, 2'b00)
		stop_test;
	end
endmodule
bind voice_trigger_mode_control voice_trigger_checker u_chk (.i_clk, .i_sys_rst, .o_sda_out,
	.o_sda_oe, .o_wake, .o_pdm_mic_clock_out, .o_digital_mic, .o_adc_ready, .o_frame_valid,
	.o_frame_data, .i_frame_ready, .i_speech_detect, .i_compare_done, .i_match, .o_extract,
	.o_low_power);
